/* logic/smrc_defines.vh */
// constants for the stop-mode recovery control block
`ifndef SMRC_DEFINES_VH
`define SMRC_DEFINES_VH
// register offset and field positions
`define SMRC_REG_ADDR      8'h0b
`define SMRC_BIT_PRESCALE  0
`define SMRC_SRC_LO        2
`define SMRC_SRC_HI        4
`define SMRC_BIT_DELAY     5
`define SMRC_BIT_POL       6
`define SMRC_BIT_WARM      7
// reset values of write-only fields
`define SMRC_RST_PRESCALE  1'h0
`define SMRC_RST_SRC       3'h0
`define SMRC_RST_DELAY     1'h1
`define SMRC_RST_POL       1'h0
// wake source codes
`define SMRC_SRC_NONE      3'h0
`define SMRC_SRC_RSVD      3'h1
`define SMRC_SRC_P3L1      3'h2
`define SMRC_SRC_P3L2      3'h3
`define SMRC_SRC_P3L3      3'h4
`define SMRC_SRC_P2L7      3'h5
`define SMRC_SRC_NOR4      3'h6
`define SMRC_SRC_NOR8      3'h7
// timing
`define SMRC_PRESCALE_DIV  16
`define SMRC_FAST_MIN_CLKS 5
`define SMRC_POR_DLY_CLKS  1024
`endif

/* logic/smrc_sync3.v */
// three-flop input synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module smrc_sync3 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst_n,
    // raw and filtered levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_r;  // first stage, read only by s2
    reg [WIDTH-1:0] s2_r;  // second stage
    reg [WIDTH-1:0] s3_r;  // third stage

    // ****************
    // shift chain
    // ****************
    // per bit: output moves only when s2 and s3 agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[i]     <= 1'b0;
                    s2_r[i]     <= 1'b0;
                    s3_r[i]     <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1_r[i] <= async_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        sync_out[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate
endmodule

/* logic/smrc_top.v */
// stop-mode recovery control with port 2 wake gating
//
// What this block does
// - bit 0 selects divide-by-16 of core and timer clocks
// - stop recovery clears the prescaler select bit
// - bits 4..2 choose single-pin wake source
// - codes 110/111 wake on NOR of port 2 lines 3..0 / all eight lines
// - port 2 outputs force wake gate default
// - bit 5 low skips power-on delay after wake
// - bit 6 picks wake level, resets to 0
// - bit 7 reads 1 after stop recovery
// - port 2 offers eight-input OR and AND
// - port 2 lines individually in or out
// - one global push-pull/open-drain setting for outputs
// - bits 6..0 write-only, bit 7 read-only
`timescale 1ns/1ps
`include "smrc_defines.vh"
module smrc_top #(
    parameter POR_DLY_CLKS = `SMRC_POR_DLY_CLKS  // wake delay in cycles
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // core state
    input  wire       stop_enter,
    output reg        stop_mode,
    output reg        wake_req,
    output reg        core_run,
    // clock enables
    output reg        sys_clk_en,
    output reg        timer_irq_clock_en,
    // port 2 control
    input  wire [7:0] port2_dir,
    input  wire       port2_open_drain,
    input  wire [7:0] port2_out_data,
    // port 2 pins
    input  wire [7:0] port2_pin_in,
    output reg  [7:0] port2_pin_out,
    output reg  [7:0] port2_pin_oe,
    output reg        port2_and,
    output reg        port2_or,
    // port 3 wake pins
    input  wire [2:0] port3_pin_in
);
    // ****************
    // declarations
    // ****************
    localparam ST_RUN   = 3'h1;  // normal execution
    localparam ST_STOP  = 3'h2;  // clocks stopped, waiting for wake
    localparam ST_DELAY = 3'h4;  // power-on delay after wake

    reg        prescale_r;       // divide-by-16 select
    reg  [2:0] src_r;            // wake source code
    reg        delay_en_r;       // power-on delay enable
    reg        pol_r;            // wake level polarity
    reg        warm_r;           // warm start flag
    reg  [2:0] state_r;          // recovery state
    reg  [2:0] state_nxt;
    reg  [3:0] div_r;            // prescaler counter
    reg [15:0] dly_r;            // wake delay counter
    wire [7:0] p2_s;             // synchronised port 2
    wire [2:0] p3_s;             // synchronised port 3
    reg  [7:0] p2_gate;          // wake gate inputs
    reg        src_lvl;          // selected source level
    wire       wake_hit;         // source matches polarity
    wire       wr_hit;

    // ****************
    // pin synchronisers
    // ****************
    smrc_sync3 #(.WIDTH(8)) u_sync_p2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (port2_pin_in),
        .sync_out (p2_s)
    );
    smrc_sync3 #(.WIDTH(3)) u_sync_p3 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (port3_pin_in),
        .sync_out (p3_s)
    );

    // ****************
    // wake gating
    // ****************
    // output lines read as 0 so the NOR ignores them
    always @* begin
        p2_gate = p2_s & ~port2_dir;
        case (src_r)
            `SMRC_SRC_P3L1: src_lvl = p3_s[0];
            `SMRC_SRC_P3L2: src_lvl = p3_s[1];
            `SMRC_SRC_P3L3: src_lvl = p3_s[2];
            `SMRC_SRC_P2L7: src_lvl = p2_gate[7];
            `SMRC_SRC_NOR4: src_lvl = ~(|p2_gate[3:0]);
            `SMRC_SRC_NOR8: src_lvl = ~(|p2_gate);
            default:        src_lvl = ~pol_r;  // no pin source, never wakes
        endcase
    end
    // nor is high only when every input line it covers is low; outputs never block it

    // match chosen level, only in stop mode
    assign wake_hit = (state_r == ST_STOP) && (src_lvl == pol_r);

    // eight-input gates; outputs read 1 into the AND, 0 into the OR
    always @* begin
        port2_and = &(p2_s | port2_dir);
        port2_or  = |p2_gate;
    end

    // ****************
    // port 2 drive
    // ****************
    // open drain drives only low; a high releases the pin
    always @* begin
        port2_pin_out = port2_out_data & {8{~port2_open_drain}};
        port2_pin_oe  = port2_dir &
                        (port2_open_drain ? ~port2_out_data : 8'hff);
    end

    // ****************
    // recovery sequence
    // ****************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:   if (stop_enter) begin
                state_nxt = ST_STOP;
            end
            ST_STOP:  if (wake_hit) begin
                state_nxt = delay_en_r ? ST_DELAY : ST_RUN;
            end
            ST_DELAY: if (dly_r == 16'h0001) begin
                state_nxt = ST_RUN;
            end
            default:  state_nxt = ST_RUN;
        endcase
    end

    // fast wake relies on the source staying active through sync
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= ST_RUN;
            dly_r    <= 16'h0000;
            wake_req <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            wake_req <= wake_hit;
            if (wake_hit) begin
                dly_r <= POR_DLY_CLKS[15:0];
            end else if (dly_r != 16'h0000) begin
                dly_r <= dly_r - 16'h0001;
            end
        end
    end

    always @* begin
        stop_mode = (state_r == ST_STOP);
        core_run  = (state_r == ST_RUN);
    end

    // ****************
    // register
    // ****************
    assign wr_hit = reg_wr && (reg_addr == `SMRC_REG_ADDR);

    // recovery clears prescale; polarity survives stop recovery
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= `SMRC_RST_PRESCALE;
            src_r      <= `SMRC_RST_SRC;
            delay_en_r <= `SMRC_RST_DELAY;
            pol_r      <= `SMRC_RST_POL;
            warm_r     <= 1'b0;
        end else begin
            if (wr_hit) begin
                prescale_r <= reg_wdata[`SMRC_BIT_PRESCALE];
                src_r      <= reg_wdata[`SMRC_SRC_HI:`SMRC_SRC_LO];
                delay_en_r <= reg_wdata[`SMRC_BIT_DELAY];
                pol_r      <= reg_wdata[`SMRC_BIT_POL];
            end
            // recovery wins over a same-cycle write
            if (wake_hit) begin
                prescale_r <= 1'b0;
                warm_r     <= 1'b1;
            end
        end
    end

    // only bit 7 is readable; write-only bits read 0
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `SMRC_REG_ADDR) begin
            reg_rdata <= {warm_r, 7'h00};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************
    // prescaler
    // ****************
    // one enable in 16 when divided; clocks stay gated in stop
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r              <= 4'h0;
            sys_clk_en         <= 1'b0;
            timer_irq_clock_en <= 1'b0;
        end else begin
            div_r              <= div_r + 4'h1;
            sys_clk_en         <= core_run &&
                                  (!prescale_r || div_r == 4'hf);
            timer_irq_clock_en <= (state_r != ST_STOP) &&
                                  (!prescale_r || div_r == 4'hf);
        end
    end
endmodule

/* test/smrc_wake_src.sv */
// external wake pins model
`timescale 1ns/1ps
module smrc_wake_src (
    // clock and pins
    input  logic       core_clk,
    output logic [7:0] port2_lines,
    output logic [2:0] port3_lines
);
    // port 2 has pull-ups, idles high
    initial begin
        port2_lines = 8'hff;
        port3_lines = 3'h7;
    end
    // hold a level for hold cycles, at least five
    task drive(input logic [7:0] p2, input logic [2:0] p3, input int hold);
        @(posedge core_clk);
        #2;
        port2_lines = p2;
        port3_lines = p3;
        repeat (hold) @(posedge core_clk);
        #2;
        port2_lines = 8'hff;
        port3_lines = 3'h7; // wake lines rest at their inactive high level
    endtask
endmodule

/* test/smrc_top_assertions.sv */
// port assertions for the recovery control block
`timescale 1ns/1ps
module smrc_top_chk (
    // watched ports
    input logic       core_clk, rst_n, reg_rd, stop_enter, stop_mode,
    input logic       wake_req, core_run, sys_clk_en, timer_irq_clock_en,
    input logic       port2_open_drain, port2_and, port2_or,
    input logic [7:0] reg_addr, reg_rdata, port2_dir, port2_out_data,
    input logic [7:0] port2_pin_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // enables are registered, so allow one edge of lag
    sequence s_held_stop;
        stop_mode [*2];
    endsequence
    sequence s_wake;
        stop_mode ##1 wake_req;
    endsequence
    chk_wake_one_cycle: assert property (wake_req |=> !wake_req)
        else $error("wake request wider than one cycle");
    chk_wake_in_stop: assert property (wake_req |-> $past(stop_mode))
        else $error("wake request outside stop");
    chk_wake_exit: assert property (s_wake |-> !stop_mode)
        else $error("stop held after wake");
    chk_enter_stop: assert property (stop_enter && core_run |=> stop_mode)
        else $error("stop not entered");
    chk_stop_gate: assert property (s_held_stop |->
        !sys_clk_en && !timer_irq_clock_en)
        else $error("clock enable in stop");
    chk_rd_other: assert property (reg_rd && reg_addr != 8'h0b |=>
        reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_low_zero: assert property (reg_rd |=> reg_rdata[6:0] == 7'h00)
        else $error("write-only bits read back");
    chk_oe_map: assert property (port2_pin_oe == (port2_dir &
        (port2_open_drain ? ~port2_out_data : 8'hff)))
        else $error("port 2 enable mismatch");
    chk_gate_mask: assert property (&port2_dir |-> port2_and && !port2_or)
        else $error("output lines not masked");
endmodule
bind smrc_top smrc_top_chk chk_u (.*);

/* test/stop_mode_recovery_control_tb_top.sv */
// testbench for the stop-mode recovery control block
`timescale 1ns/1ps
module stop_mode_recovery_control_tb_top;
    // ****************
    // signals
    // ****************
    logic       core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic       stop_enter = 0, port2_open_drain = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, port2_dir = 0, port2_out_data = 0;
    wire  [7:0] reg_rdata, port2_pin_out, port2_pin_oe, src_p2, port2_pin_in;
    wire        stop_mode, wake_req, core_run, sys_clk_en, timer_irq_clock_en;
    wire        port2_and, port2_or;
    wire  [2:0] port3_pin_in;
    int         fails = 0, checks = 0, c;
    always #12.5 core_clk = ~core_clk;
    // pin level: driven by whoever has the enable
    assign port2_pin_in = (port2_pin_oe & port2_pin_out) | (~port2_pin_oe & src_p2);
    // short power-on delay keeps the run brief
    smrc_top #(.POR_DLY_CLKS(8)) dut_u (.*);
    smrc_wake_src src_u (.core_clk(core_clk), .port2_lines(src_p2),
        .port3_lines(port3_pin_in));
    // ****************
    // tasks
    // ****************
    task tick; @(posedge core_clk); #2; endtask
    task chk(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, d);
        reg_addr = a; reg_wdata = d; reg_wr = 1; tick; reg_wr = 0; tick;
    endtask
    task rd(input logic [7:0] a, e);
        reg_addr = a; reg_rd = 1; tick; reg_rd = 0;
        chk("rdata", reg_rdata, e);
        tick;
    endtask
    task rst; rst_n = 0; repeat (10) tick; rst_n = 1; tick; endtask
    // run cycles counted over 32 clocks
    task cnt(input logic [7:0] e);
        logic [7:0] n;
        n = 0;
        repeat (32) begin
            tick; n = n + {7'h0, sys_clk_en & timer_irq_clock_en};
        end
        chk("run_en", n, e);
    endtask
    // enter stop, let the pins act, expect a wake
    task wake(input logic [7:0] stop_recovery_control, dir, p2, input logic [2:0] p3, input logic r);
        logic got;
        got = 0;
        port2_dir = dir; wr(8'h0b, stop_recovery_control);
        stop_enter = 1; tick; stop_enter = 0; tick;
        chk("stop", stop_mode, 1);
        fork
            src_u.drive(p2, p3, 8);
            for (int i = 0; i < 40 && !got; i++) begin
                tick; got = (wake_req === 1'b1);
                if (got) chk("run", core_run, r);
            end
        join
        chk("wake", got, 1);
        repeat (12) tick;
        rd(8'h0b, 8'h80);
        cnt(32);
    endtask
    task final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        rst;
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h00);
        chk("oe", port2_pin_oe, 8'h00);
        wr(8'h0b, 8'h21); tick; cnt(2);
        chk("and", port2_and, 1);
        chk("or", port2_or, 1);
        port2_dir = 8'hff; port2_open_drain = 1; port2_out_data = 8'h05; tick;
        chk("oe", port2_pin_oe, 8'hfa);
        chk("out", port2_pin_out, 8'h00);
        port2_open_drain = 0; tick;
        chk("or", port2_or, 0);
        chk("oe", port2_pin_oe, 8'hff);
        chk("out", port2_pin_out, 8'h05);
        // single pins, low level, fast wake
        for (c = 2; c < 6; c++)
            wake({3'h0, c[2:0], 2'h1}, 8'h00, c == 5 ? 8'h7f : 8'hff,
                c == 5 ? 3'h7 : ~(3'h1 << (c - 2)), 1'b0 | 1'b1);
        // nor sources, high level, delayed; outputs driven high must not block
        port2_out_data = 8'hff;
        wake(8'h79, 8'h01, 8'hf1, 3'h7, 1'b0);
        wake(8'h7d, 8'hf0, 8'hf0, 3'h7, 1'b0);
        // no source, reserved and a partly low nor never wake
        for (c = 0; c < 3; c++) begin
            port2_dir = 8'h00;
            wr(8'h0b, c == 2 ? 8'h5c : {3'h0, c[2:0], 2'h0});
            stop_enter = 1; tick; stop_enter = 0;
            src_u.drive(c == 2 ? 8'h0f : 8'h00, 3'h0, 8);
            repeat (10) tick;
            chk("stop", stop_mode, 1);
            rst;
            rd(8'h0b, 8'h00);
        end
        final_report;
    end
    // hang guard, far beyond the expected run
    initial begin
        #1000000;
        fails++;
        final_report;
    end
endmodule
